// ### kchc_pkg.sv
`default_nettype none
package kchc_pkg;
   // system clock rate and derived execution clock
   localparam int unsigned SYS_CLK_HZ = 50000000;
   localparam int unsigned EXEC_CLK_HZ = 2000000;
   localparam int unsigned EXEC_DIV = SYS_CLK_HZ / EXEC_CLK_HZ;
   localparam logic [4:0] EXEC_DIV_LAST = 5'(EXEC_DIV - 1);
   // pwm prescale of the execution clock
   localparam int unsigned PWM_PRESCALE = 64;
   localparam logic [5:0] PWM_PRESCALE_HALF = 6'(PWM_PRESCALE / 2);
   // register offsets
   localparam logic [3:0] OFS_CLOCK_CFG = 4'h0;
   localparam logic [3:0] OFS_HALT_TIME = 4'h1;
   localparam logic [3:0] OFS_PIN_CFG = 4'h2;
   localparam logic [3:0] OFS_STATUS = 4'h3;
   localparam logic [3:0] OFS_KEY_STATUS = 4'h4;
   // clock configuration fields
   localparam int unsigned CFG_BUF_EN_BIT = 6;
   localparam int unsigned CFG_SLOW_EN_BIT = 3;
   localparam int unsigned CFG_SEL_LSB = 0;
   localparam logic [7:0] CLOCK_CFG_RESET = 8'h00;
   // timebase select codes
   localparam logic [1:0] SEL_RC_DIV = 2'h0;
   localparam logic [1:0] SEL_EXT = 2'h3;
   // pin configuration fields
   localparam int unsigned PIN_PUSH_PULL_BIT = 0;
   localparam int unsigned PIN_ADDR_RELEASE_BIT = 1;
   localparam logic [7:0] PIN_CFG_RESET = 8'h00;
   // halt timer, in execution clock ticks per unit
   localparam logic [15:0] HALT_TIME_RESET = 16'h00FF;
   // key matrix
   localparam int unsigned KEY_COLS = 8;
   localparam int unsigned KEY_ROWS = 12;
   typedef enum logic [1:0] {
      KCHC_RUN = 2'b00,
      KCHC_HALT = 2'b01
   } kchc_state_e;
endpackage : kchc_pkg
`default_nettype wire

// ### kchc_clk_sync.sv
`default_nettype none
// two flop synchroniser plus a rising edge output for slow async clock inputs
module kchc_clk_sync (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic async_i,
   output logic level_o,
   output logic rise_o
);
   logic meta_q, meta_d;
   logic sync_q, sync_d;
   logic last_q, last_d;

   // first flop only feeds second, edge taken after the pair
   always_comb begin
      meta_d = async_i;
      sync_d = meta_q;
      last_d = sync_q;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         last_q <= last_d;
      end
   end

   assign level_o = sync_q;
   assign rise_o = sync_q & ~last_q;
endmodule : kchc_clk_sync
`default_nettype wire

// ### kchc_key_prio.sv
`default_nettype none
// per row, special-function key beats ordinary matrix keys
module kchc_key_prio (
   input wire logic [7:0] sf_key_n_i,
   input wire logic [7:0] row_hit_i,
   output logic [7:0] report_sf_o,
   output logic [7:0] report_matrix_o,
   output logic wake_o
);
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_row
         // sf key pulls its line low; it masks the matrix key of that row
         assign report_sf_o[g] = ~sf_key_n_i[g];
         assign report_matrix_o[g] = row_hit_i[g] & sf_key_n_i[g];
      end
   endgenerate

   // any grounded wakeup line is a wake event
   assign wake_o = ~&sf_key_n_i;
endmodule : kchc_key_prio
`default_nettype wire

// ### kchc_clock_ctrl.sv
`default_nettype none
module kchc_clock_ctrl (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic external_32k_clock_input_i,
   input wire logic oscillator_input_pin_i,
   input wire logic [7:0] wakeup_input_line_n_i,
   input wire logic [7:0] row_hit_i,
   input wire logic key_event_i,
   input wire logic bus_start_i,
   input wire logic [1:0] addr_sel_i,
   input wire logic irq_req_i,
   input wire logic pin_shared_gpio_i,
   input wire logic pin_shared_gpio_oe_i,
   output logic exec_tick_o,
   output logic pwm_tick_o,
   output logic halted_o,
   output logic [1:0] bus_addr_o,
   output logic addr_pins_free_o,
   output logic irq_n_o,
   output logic irq_n_oe_o,
   output logic buffered_timebase_output_o,
   output logic buffered_timebase_output_oe_o,
   output logic [11:0] keypad_out_o,
   output logic [11:0] keypad_out_oe_o,
   output logic [7:0] keypad_in_oe_o,
   output logic [7:0] report_sf_o,
   output logic [7:0] report_matrix_o
);
   // synchronised slow sources; only levels are used, edges come from the timebase flop
   logic ext_lvl, osc_lvl;
   logic sf_wake;
   logic [7:0] rep_sf, rep_mx;

   kchc_clk_sync u_ext_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .async_i(external_32k_clock_input_i),
      .level_o(ext_lvl),
      .rise_o()
   );

   kchc_clk_sync u_osc_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .async_i(oscillator_input_pin_i),
      .level_o(osc_lvl),
      .rise_o()
   );

   kchc_key_prio u_key_prio (
      .sf_key_n_i(wakeup_input_line_n_i),
      .row_hit_i(row_hit_i),
      .report_sf_o(rep_sf),
      .report_matrix_o(rep_mx),
      .wake_o(sf_wake)
   );

   // software registers
   logic [7:0] clock_cfg_q, clock_cfg_d;
   logic [15:0] halt_time_q, halt_time_d;
   logic [7:0] pin_cfg_q, pin_cfg_d;
   logic cfg_written_q, cfg_written_d;
   logic [15:0] rdata_q, rdata_d;
   // status sources, declared ahead of the read decode that packs them
   logic [1:0] bus_addr_q, bus_addr_d;
   logic [1:0] sel_eff_q, sel_eff_d;
   logic halted_q, halted_d;

   // reads of an unmapped offset return zero
   always_comb begin
      clock_cfg_d = clock_cfg_q;
      halt_time_d = halt_time_q;
      pin_cfg_d = pin_cfg_q;
      cfg_written_d = cfg_written_q;
      rdata_d = 16'h0000;
      if (wr_i) begin
         unique case (addr_i)
            kchc_pkg::OFS_CLOCK_CFG: begin
               // clock config taken once; later writes ignored
               if (!cfg_written_q) begin
                  clock_cfg_d = wdata_i[7:0];
                  cfg_written_d = 1'b1;
               end
            end
            kchc_pkg::OFS_HALT_TIME: halt_time_d = wdata_i;
            kchc_pkg::OFS_PIN_CFG: pin_cfg_d = wdata_i[7:0];
            default: ;
         endcase
      end
      if (rd_i) begin
         unique case (addr_i)
            kchc_pkg::OFS_CLOCK_CFG: rdata_d = {8'h00, clock_cfg_q};
            kchc_pkg::OFS_HALT_TIME: rdata_d = halt_time_q;
            kchc_pkg::OFS_PIN_CFG: rdata_d = {8'h00, pin_cfg_q};
            kchc_pkg::OFS_STATUS:
               rdata_d = {10'h000, cfg_written_q, bus_addr_q, sel_eff_q, halted_q};
            kchc_pkg::OFS_KEY_STATUS: rdata_d = {rep_sf, rep_mx};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   // software registers, reset to defaults on any reset
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         clock_cfg_q <= kchc_pkg::CLOCK_CFG_RESET;
         halt_time_q <= kchc_pkg::HALT_TIME_RESET;
         pin_cfg_q <= kchc_pkg::PIN_CFG_RESET;
         cfg_written_q <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         clock_cfg_q <= clock_cfg_d;
         halt_time_q <= halt_time_d;
         pin_cfg_q <= pin_cfg_d;
         cfg_written_q <= cfg_written_d;
         rdata_q <= rdata_d;
      end
   end

   // execution clock prescaler and halt state
   kchc_pkg::kchc_state_e state_q, state_d;
   logic [4:0] exec_cnt_q, exec_cnt_d;
   logic exec_tick_q, exec_tick_d;
   logic [15:0] idle_cnt_q, idle_cnt_d;
   logic wake;

   // reset wakes implicitly through the reset branch below
   assign wake = key_event_i | bus_start_i | sf_wake | wr_i | rd_i;

   always_comb begin
      state_d = state_q;
      exec_cnt_d = exec_cnt_q;
      exec_tick_d = 1'b0;
      idle_cnt_d = idle_cnt_q;
      unique case (state_q)
         kchc_pkg::KCHC_RUN: begin
            // system clock divided into the execution clock tick
            if (exec_cnt_q == kchc_pkg::EXEC_DIV_LAST) begin
               exec_cnt_d = 5'h00;
               exec_tick_d = 1'b1;
               if (wake) begin
                  idle_cnt_d = 16'h0000;
               end else if (idle_cnt_q >= halt_time_q) begin
                  state_d = kchc_pkg::KCHC_HALT;
               end else begin
                  idle_cnt_d = idle_cnt_q + 16'h0001;
               end
            end else begin
               exec_cnt_d = exec_cnt_q + 5'h01;
               if (wake) begin
                  idle_cnt_d = 16'h0000;
               end
            end
         end
         kchc_pkg::KCHC_HALT: begin
            // no ticks while halted
            exec_cnt_d = 5'h00;
            idle_cnt_d = 16'h0000;
            if (wake) begin
               state_d = kchc_pkg::KCHC_RUN;
            end
         end
         default: state_d = kchc_pkg::KCHC_RUN;
      endcase
      halted_d = (state_d == kchc_pkg::KCHC_HALT);
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_q <= kchc_pkg::KCHC_RUN;
         exec_cnt_q <= 5'h00;
         exec_tick_q <= 1'b0;
         idle_cnt_q <= 16'h0000;
         halted_q <= 1'b0;
      end else begin
         state_q <= state_d;
         exec_cnt_q <= exec_cnt_d;
         exec_tick_q <= exec_tick_d;
         idle_cnt_q <= idle_cnt_d;
         halted_q <= halted_d;
      end
   end

   // pwm prescaler produces a square wave from execution ticks
   logic [5:0] pre_cnt_q, pre_cnt_d;
   logic pre_clk_q, pre_clk_d;
   always_comb begin
      pre_cnt_d = pre_cnt_q;
      pre_clk_d = pre_clk_q;
      if (exec_tick_q) begin
         if (pre_cnt_q == kchc_pkg::PWM_PRESCALE_HALF - 6'h01) begin
            pre_cnt_d = 6'h00;
            pre_clk_d = ~pre_clk_q;
         end else begin
            pre_cnt_d = pre_cnt_q + 6'h01;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pre_cnt_q <= 6'h00;
         pre_clk_q <= 1'b0;
      end else begin
         pre_cnt_q <= pre_cnt_d;
         pre_clk_q <= pre_clk_d;
      end
   end

   // timebase selection; switch only while both old and new are low
   logic [1:0] sel_req;
   logic ext_src, new_lvl, cur_lvl;
   logic tb_q, tb_d;
   logic tb_last_q, tb_last_d;

   // reserved codes fall back to the prescaled clock
   assign sel_req = (clock_cfg_q[kchc_pkg::CFG_SEL_LSB +: 2] == kchc_pkg::SEL_EXT)
                    ? kchc_pkg::SEL_EXT : kchc_pkg::SEL_RC_DIV;
   // enable bit picks the pin source: 1 external clock, 0 crystal
   assign ext_src = clock_cfg_q[kchc_pkg::CFG_SLOW_EN_BIT] ? ext_lvl : osc_lvl;
   assign new_lvl = (sel_req == kchc_pkg::SEL_EXT) ? ext_src : pre_clk_q;
   assign cur_lvl = (sel_eff_q == kchc_pkg::SEL_EXT) ? ext_src : pre_clk_q;

   always_comb begin
      sel_eff_d = sel_eff_q;
      if (sel_req != sel_eff_q && !cur_lvl && !new_lvl) begin
         sel_eff_d = sel_req;
      end
      tb_d = cur_lvl;
      tb_last_d = tb_q;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sel_eff_q <= kchc_pkg::SEL_RC_DIV;
         tb_q <= 1'b0;
         tb_last_q <= 1'b0;
      end else begin
         sel_eff_q <= sel_eff_d;
         tb_q <= tb_d;
         tb_last_q <= tb_last_d;
      end
   end

   // address strap captured at reset release, pins freed after it once the pin config release bit is set
   logic strap_done_q, strap_done_d;
   always_comb begin
      bus_addr_d = bus_addr_q;
      strap_done_d = 1'b1;
      if (!strap_done_q) begin
         bus_addr_d = addr_sel_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         bus_addr_q <= 2'h0;
         strap_done_q <= 1'b0;
      end else begin
         bus_addr_q <= bus_addr_d;
         strap_done_q <= strap_done_d;
      end
   end

   // registered pin drivers
   logic irq_n_d, irq_oe_d, buf_d, buf_oe_d, free_d, pwm_tick_d;
   logic [11:0] kout_d, kout_oe_d;
   logic [7:0] kin_oe_d;
   logic irq_n_q, irq_oe_q, buf_q, buf_oe_q, free_q, pwm_tick_q;
   logic [11:0] kout_q, kout_oe_q;
   logic [7:0] kin_oe_q;
   logic [7:0] rsf_q, rmx_q;
   logic buf_en;

   assign buf_en = clock_cfg_q[kchc_pkg::CFG_BUF_EN_BIT];

   always_comb begin
      // open drain drives only low; push-pull drives both levels
      irq_n_d = ~irq_req_i;
      irq_oe_d = pin_cfg_q[kchc_pkg::PIN_PUSH_PULL_BIT] | irq_req_i;
      // shared pin: clock buffer wins over gpio
      buf_d = buf_en ? tb_q : pin_shared_gpio_i;
      buf_oe_d = buf_en | pin_shared_gpio_oe_i;
      free_d = strap_done_q & pin_cfg_q[kchc_pkg::PIN_ADDR_RELEASE_BIT];
      pwm_tick_d = tb_q & ~tb_last_q;
      // dedicated scan outputs low, the rest released
      kout_d = 12'h000;
      kout_oe_d = 12'h007;
      // input lines never driven; line seven is input only
      kin_oe_d = 8'h00;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         irq_n_q <= 1'b1;
         irq_oe_q <= 1'b0;
         buf_q <= 1'b0;
         buf_oe_q <= 1'b0;
         free_q <= 1'b0;
         pwm_tick_q <= 1'b0;
         kout_q <= 12'h000;
         kout_oe_q <= 12'h000;
         kin_oe_q <= 8'h00;
         rsf_q <= 8'h00;
         rmx_q <= 8'h00;
      end else begin
         irq_n_q <= irq_n_d;
         irq_oe_q <= irq_oe_d;
         buf_q <= buf_d;
         buf_oe_q <= buf_oe_d;
         free_q <= free_d;
         pwm_tick_q <= pwm_tick_d;
         kout_q <= kout_d;
         kout_oe_q <= kout_oe_d;
         kin_oe_q <= kin_oe_d;
         rsf_q <= rep_sf;
         rmx_q <= rep_mx;
      end
   end

   assign rdata_o = rdata_q;
   assign exec_tick_o = exec_tick_q;
   assign pwm_tick_o = pwm_tick_q;
   assign halted_o = halted_q;
   assign bus_addr_o = bus_addr_q;
   assign addr_pins_free_o = free_q;
   assign irq_n_o = irq_n_q;
   assign irq_n_oe_o = irq_oe_q;
   assign buffered_timebase_output_o = buf_q;
   assign buffered_timebase_output_oe_o = buf_oe_q;
   assign keypad_out_o = kout_q;
   assign keypad_out_oe_o = kout_oe_q;
   assign keypad_in_oe_o = kin_oe_q;
   assign report_sf_o = rsf_q;
   assign report_matrix_o = rmx_q;
endmodule : kchc_clock_ctrl
`default_nettype wire

// ### kchc_ctrl_asserts.sv
`default_nettype none
module kchc_ctrl_asserts (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic rd_i,
   input wire logic [15:0] rdata_o,
   input wire logic key_event_i,
   input wire logic bus_start_i,
   input wire logic [1:0] addr_sel_i,
   input wire logic irq_req_i,
   input wire logic exec_tick_o,
   input wire logic pwm_tick_o,
   input wire logic halted_o,
   input wire logic [1:0] bus_addr_o,
   input wire logic irq_n_o,
   input wire logic irq_n_oe_o,
   input wire logic [11:0] keypad_out_o,
   input wire logic [11:0] keypad_out_oe_o,
   input wire logic [7:0] keypad_in_oe_o,
   input wire logic [7:0] report_sf_o,
   input wire logic [7:0] report_matrix_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_exec_tick_spacing: assert property (exec_tick_o && !halted_o |=>
      !exec_tick_o [*8] ##17 (exec_tick_o || halted_o)) else $error("exec tick spacing");
   a_halt_no_tick: assert property (halted_o && $past(halted_o) |-> !exec_tick_o)
      else $error("exec tick in halt");
   a_wake_on_event: assert property (halted_o && (key_event_i || bus_start_i)
      |-> ##[1:3] !halted_o) else $error("no wake");
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
      else $error("read data not idle");
   a_irq_drive: assert property (irq_req_i ##1 irq_req_i |-> irq_n_oe_o && !irq_n_o)
      else $error("irq not driven");
   a_irq_release: assert property (!irq_req_i ##1 !irq_req_i |-> !(irq_n_oe_o && !irq_n_o))
      else $error("irq low without request");
   a_scan_hiz: assert property (keypad_out_o == 12'h000 && keypad_out_oe_o[11:3] == 9'h000
      && keypad_in_oe_o == 8'h00) else $error("keypad lines driven");
   a_scan_low: assert property (rst_n_i ##1 rst_n_i |-> keypad_out_oe_o[2:0] == 3'h7)
      else $error("dedicated scan not driven");
   a_sf_wins: assert property ((report_sf_o & report_matrix_o) == 8'h00)
      else $error("row reported twice");
   a_strap_take: assert property ($rose(rst_n_i) |=> bus_addr_o == $past(addr_sel_i))
      else $error("strap not captured");
   a_pwm_pulse: assert property (pwm_tick_o |=> !pwm_tick_o [*8])
      else $error("pwm tick too close");
endmodule : kchc_ctrl_asserts
bind kchc_clock_ctrl kchc_ctrl_asserts i_chk (.mclk_i, .rst_n_i, .rd_i, .rdata_o, .key_event_i,
   .bus_start_i, .addr_sel_i, .irq_req_i, .exec_tick_o, .pwm_tick_o, .halted_o, .bus_addr_o,
   .irq_n_o, .irq_n_oe_o, .keypad_out_o, .keypad_out_oe_o, .keypad_in_oe_o, .report_sf_o,
   .report_matrix_o);
`default_nettype wire

// ### kchc_slow_src.sv
`default_nettype none
// far side: free-running slow clock and crystal, no phase tie to mclk
module kchc_slow_src #(
   parameter int EXT_HALF_NS = 15259,
   parameter int OSC_HALF_NS = 15000
) (
   output var logic ext_clk_o,
   output var logic osc_clk_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // both run free, as a real source would
   initial begin
      ext_clk_o = 1'b0;
      #3.7;
      forever #(EXT_HALF_NS) ext_clk_o = ~ext_clk_o;
   end
   initial begin
      osc_clk_o = 1'b1;
      #7.3;
      forever #(OSC_HALF_NS) osc_clk_o = ~osc_clk_o;
   end
endmodule : kchc_slow_src
`default_nettype wire

// ### tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int EXT_P = 1526;
   localparam int OSC_P = 1500;
   localparam int RC_P = 1600; // 25 * 64 mclk
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0, rd_i = 1'b0, key_event_i = 1'b0, bus_start_i = 1'b0;
   logic [7:0] wakeup_input_line_n_i = 8'hFF, row_hit_i = 8'h00;
   logic [1:0] addr_sel_i = 2'h0;
   logic irq_req_i = 1'b0, pin_shared_gpio_i = 1'b0, pin_shared_gpio_oe_i = 1'b0;
   wire external_32k_clock_input_i, oscillator_input_pin_i;
   logic [15:0] rdata_o;
   logic exec_tick_o, pwm_tick_o, halted_o, addr_pins_free_o, irq_n_o, irq_n_oe_o;
   logic buffered_timebase_output_o, buffered_timebase_output_oe_o;
   logic [1:0] bus_addr_o;
   logic [11:0] keypad_out_o, keypad_out_oe_o;
   logic [7:0] keypad_in_oe_o, report_sf_o, report_matrix_o;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   int n;
   logic [15:0] rv;
   logic [15:0] cfg [4] = '{16'h004B, 16'h0003, 16'h0041, 16'h0002};
   int per [4] = '{EXT_P, OSC_P, RC_P, RC_P};
   logic [1:0] sel [4] = '{2'h3, 2'h3, 2'h0, 2'h0};

   kchc_slow_src i_src (.ext_clk_o(external_32k_clock_input_i),
      .osc_clk_o(oscillator_input_pin_i));
   kchc_clock_ctrl i_dut (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .external_32k_clock_input_i, .oscillator_input_pin_i, .wakeup_input_line_n_i,
      .row_hit_i, .key_event_i, .bus_start_i, .addr_sel_i, .irq_req_i, .pin_shared_gpio_i,
      .pin_shared_gpio_oe_i, .exec_tick_o, .pwm_tick_o, .halted_o, .bus_addr_o,
      .addr_pins_free_o, .irq_n_o, .irq_n_oe_o, .buffered_timebase_output_o,
      .buffered_timebase_output_oe_o, .keypad_out_o, .keypad_out_oe_o, .keypad_in_oe_o,
      .report_sf_o, .report_matrix_o);

   // 50 MHz system clock
   always #10 mclk_i = ~mclk_i;

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   // hang guard, well above the longest expected run
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         test_done();
      end
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 rv = rdata_o;
   endtask : rd

   task automatic do_reset();
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      addr_sel_i <= 2'($urandom);
      repeat (6) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
   endtask : do_reset

   function automatic logic [15:0] stat(input logic cw, input logic [1:0] s);
      return {10'h000, cw, addr_sel_i, s, 1'b0};
   endfunction : stat

   function automatic logic tk(input bit pwm);
      return pwm ? pwm_tick_o : exec_tick_o;
   endfunction : tk

   // edges from one tick to the next; the first wait aligns to a tick
   task automatic period(input bit pwm, input int lim);
      int i;
      i = 0;
      do begin
         @(posedge mclk_i);
         #1 i++;
      end while (tk(pwm) !== 1'b1 && i < lim);
      n = 0;
      do begin
         @(posedge mclk_i);
         #1 n++;
      end while (tk(pwm) !== 1'b1 && n < lim);
   endtask : period

   task automatic chk_per(input int e);
      chk("tick period", 16'(e), (n >= e - 2 && n <= e + 2) ? 16'(e) : 16'(n));
   endtask : chk_per

   task automatic wait_halt(input logic w, input int lim);
      int i;
      i = 0;
      // never look at the state flop in the time step of its launching edge
      #1;
      while (halted_o !== w && i < lim) begin
         @(posedge mclk_i);
         #1 i++;
      end
      chk("halted", {15'h0000, w}, {15'h0000, halted_o});
   endtask : wait_halt

   initial begin
      void'($urandom(46));
      do_reset();
      // reset values and an unmapped offset
      rd(kchc_pkg::OFS_CLOCK_CFG);
      chk("clock_cfg", 16'(kchc_pkg::CLOCK_CFG_RESET), rv);
      rd(kchc_pkg::OFS_HALT_TIME);
      chk("halt_time", kchc_pkg::HALT_TIME_RESET, rv);
      rd(kchc_pkg::OFS_PIN_CFG);
      chk("pin_cfg", 16'(kchc_pkg::PIN_CFG_RESET), rv);
      rd(kchc_pkg::OFS_STATUS);
      chk("status", stat(1'b0, 2'h0), rv);
      rd(4'hF);
      chk("unmapped", 16'h0000, rv);
      wr(kchc_pkg::OFS_HALT_TIME, 16'hFFFF);
      period(1'b0, 60);
      chk_per(25);
      period(1'b1, 2 * RC_P);
      chk_per(RC_P);
      chk("addr pins free", 16'h0000, {15'h0000, addr_pins_free_o});
      // open drain first, then push-pull with address pins released
      @(posedge mclk_i) irq_req_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      #1 chk("irq od", 16'h0002, {14'h0000, irq_n_oe_o, irq_n_o});
      @(posedge mclk_i) irq_req_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      #1 chk("irq od idle", 16'h0000, {15'h0000, irq_n_oe_o});
      wr(kchc_pkg::OFS_PIN_CFG, 16'h0003);
      repeat (3) @(posedge mclk_i);
      #1 chk("irq pp", 16'h0007, {13'h0000, irq_n_oe_o, irq_n_o, addr_pins_free_o});
      // random key patterns: a special key wins its row
      for (int k = 0; k < 8; k++) begin
         @(posedge mclk_i);
         wakeup_input_line_n_i <= 8'($urandom);
         row_hit_i <= 8'($urandom);
         repeat (3) @(posedge mclk_i);
         #1 chk("key report", {~wakeup_input_line_n_i, row_hit_i & wakeup_input_line_n_i},
            {report_sf_o, report_matrix_o});
      end
      @(posedge mclk_i);
      wakeup_input_line_n_i <= 8'hFF;
      row_hit_i <= 8'h00;
      // short idle time, then key event, bus start and wakeup line wakes in turn
      wr(kchc_pkg::OFS_HALT_TIME, 16'h0004);
      for (int k = 0; k < 3; k++) begin
         wait_halt(1'b1, 1000);
         n = 0;
         repeat (100) begin
            @(posedge mclk_i);
            #1 n += int'(exec_tick_o === 1'b1);
         end
         chk("halt ticks", 16'h0000, 16'(n));
         @(posedge mclk_i);
         case (k)
            0: key_event_i <= 1'b1;
            1: bus_start_i <= 1'b1;
            default: wakeup_input_line_n_i <= 8'hFE;
         endcase
         @(posedge mclk_i);
         key_event_i <= 1'b0;
         bus_start_i <= 1'b0;
         wait_halt(1'b0, 10);
         @(posedge mclk_i);
         wakeup_input_line_n_i <= 8'hFF;
      end
      wait_halt(1'b1, 1000);
      do_reset();
      #1 chk("halted after reset", 16'h0000, {15'h0000, halted_o});
      // each timebase, with a second clock write that must be ignored
      for (int k = 0; k < 4; k++) begin
         do_reset();
         wr(kchc_pkg::OFS_HALT_TIME, 16'hFFFF);
         wr(kchc_pkg::OFS_CLOCK_CFG, cfg[k]);
         wr(kchc_pkg::OFS_CLOCK_CFG, 16'h0000);
         pin_shared_gpio_i <= 1'($urandom);
         pin_shared_gpio_oe_i <= 1'($urandom);
         period(1'b1, 2 * per[k]);
         period(1'b1, 2 * per[k]);
         chk_per(per[k]);
         rd(kchc_pkg::OFS_CLOCK_CFG);
         chk("clock_cfg once", cfg[k], rv);
         rd(kchc_pkg::OFS_STATUS);
         chk("status sel", stat(1'b1, sel[k]), rv);
         if (cfg[k][kchc_pkg::CFG_BUF_EN_BIT]) begin
            chk("buf oe", 16'h0001, {15'h0000, buffered_timebase_output_oe_o});
         end else begin
            chk("gpio pass", {14'h0000, pin_shared_gpio_oe_i, pin_shared_gpio_i},
               {14'h0000, buffered_timebase_output_oe_o, buffered_timebase_output_o});
         end
      end
      test_done();
   end
endmodule : tb_top
`default_nettype wire
